// ===== adcc_pkg.sv
package adcc_pkg;
  // ****************************************************************
  // Register map (byte addresses) and bus
  // ****************************************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [4:0] OFS_CTRL_FIRST = 5'h00;
  localparam logic [4:0] OFS_CTRL_SECOND = 5'h04;
  localparam logic [4:0] OFS_RES_HIGH = 5'h08;
  localparam logic [4:0] OFS_RES_LOW = 5'h0c;
  localparam logic [4:0] OFS_PIN_FUNC = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int C0_START = 7;
  localparam int C0_PWR = 5;
  localparam int C0_ALIGN = 4;
  localparam int C1_SRC = 5;
  localparam int C1_VREF = 3;
  localparam int C1_DIV = 0;
  localparam int PF_REF = 4;
  localparam int IRQ_FLAG = 0;
  // ****************************************************************
  // Converter constants
  // ****************************************************************
  localparam int RES_W = 12;
  localparam int CHAN_PINS = 4;
  localparam int DIV_CNT_W = 7;
  localparam logic [3:0] SAMPLE_TICKS = 4'h4;
  localparam logic [3:0] CONV_TICKS = 4'hc;
  localparam logic [4:0] TOTAL_TICKS = 5'h10;
  localparam logic [11:0] SAR_INIT = 12'h800;
  localparam logic [1:0] VREF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_PIN_IS_REF = 2'h1;
  localparam logic [2:0] SRC_BANDGAP = 3'h1;
  localparam logic [2:0] SRC_SMOKE_A = 3'h2;
  localparam logic [2:0] SRC_SMOKE_B = 3'h3;
  localparam logic [2:0] SRC_LINE = 3'h4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcc_state_t;

  typedef struct packed {
    logic start;
    logic pwr;
    logic align;
    logic [3:0] chan;
    logic [2:0] src;
    logic [1:0] vref;
    logic [2:0] div;
  } adcc_ctrl_t;

  // One-hot pin select; codes equal to or above the pin count float
  function automatic logic [3:0] adcc_onehot4(input logic [3:0] code);
    adcc_onehot4 = 4'h0;
    if (code < 4'(CHAN_PINS)) begin
      adcc_onehot4[code[1:0]] = 1'b1;
    end
  endfunction

  // Result pair {high, low} in the chosen alignment, unused bits zero
  function automatic logic [15:0] adcc_format(input logic [11:0] d, input logic right);
    if (right) begin
      adcc_format = {4'h0, d};
    end else begin
      adcc_format = {d, 4'h0};
    end
  endfunction
endpackage

// ===== adcc_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_clkdiv
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Divider code and converter clock tick
  input wire logic [2:0] i_div,
  output logic o_tick
);
  logic [DIV_CNT_W-1:0] cnt_q, cnt_d;
  logic [DIV_CNT_W-1:0] mask;
  logic tick_d;

  // ****************************************************************
  // Power-of-two divider
  // ****************************************************************
  always_comb begin
    mask = DIV_CNT_W'((8'h01 << i_div) - 8'h01);
    cnt_d = cnt_q + 7'h01;
    tick_d = ((cnt_q & mask) == mask);
  end

  // Register counter and tick
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 7'h00;
      o_tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_tick <= tick_d;
    end
  end

  a_div_pass_thru: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_div == 3'h0 && $past(i_div) == 3'h0 && $past(i_rst_n)) |-> o_tick)
    else $error("Code 000 must tick every cycle");
  a_div_by_two: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_tick && i_div == 3'h1 && $past(i_div) == 3'h1) ##1 (i_div == 3'h1)
      |-> !o_tick ##1 o_tick)
    else $error("Code 001 must tick every second cycle");
endmodule
`default_nettype wire

// ===== adcc_pinmux.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_pinmux
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Configuration
  input wire logic [3:0] i_analog_en,
  input wire logic [1:0] i_ref_fn,
  input wire logic [3:0] i_chan,
  input wire logic [2:0] i_src,
  input wire logic [1:0] i_vref,
  // Port logic requests
  input wire logic [3:0] i_port_oe,
  input wire logic [3:0] i_port_pullhigh,
  // Pin and analog switch controls
  output logic [3:0] o_pin_oe,
  output logic [3:0] o_pin_pullhigh,
  output logic o_vref_pin_ref,
  output logic o_ref_supply,
  output logic [3:0] o_ext_connect,
  output logic [3:0] o_int_connect
);
  logic [3:0] oe_d, ph_d, ext_d, int_d;
  logic ext_src;

  // ****************************************************************
  // Pin takeover and source routing
  // ****************************************************************
  always_comb begin
    oe_d = i_port_oe & ~i_analog_en;
    ph_d = i_port_pullhigh & ~i_analog_en;
    ext_src = (i_src == 3'h0) || (i_src > SRC_LINE);
    ext_d = ext_src ? adcc_onehot4(i_chan) : 4'h0;
    int_d = 4'h0;
    case (i_src)
      SRC_BANDGAP: int_d = 4'h1;
      SRC_SMOKE_A: int_d = 4'h2;
      SRC_SMOKE_B: int_d = 4'h4;
      SRC_LINE: int_d = 4'h8;
      default: int_d = 4'h0;
    endcase
  end

  // Register the switch controls
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_oe <= 4'h0;
      o_pin_pullhigh <= 4'h0;
      o_vref_pin_ref <= 1'b0;
      o_ref_supply <= 1'b0;
      o_ext_connect <= 4'h0;
      o_int_connect <= 4'h0;
    end else begin
      o_pin_oe <= oe_d;
      o_pin_pullhigh <= ph_d;
      o_vref_pin_ref <= (i_ref_fn == REF_PIN_IS_REF);
      o_ref_supply <= (i_vref == VREF_SUPPLY);
      o_ext_connect <= ext_d;
      o_int_connect <= int_d;
    end
  end

  a_pin_no_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_analog_en[0] |=> !o_pin_oe[0])
    else $error("Analog pin still driven by port");
  a_pin_no_pull: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_analog_en[1] |=> !o_pin_pullhigh[1])
    else $error("Pull-high left on analog pin");
  a_ref_select: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_vref == 2'h2) |=> !o_ref_supply)
    else $error("Code 10 must select reference pin");
  a_chan_float: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_chan >= 4'h4) |=> (o_ext_connect == 4'h0))
    else $error("Nonexistent channel must float");
  a_src_line: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_src == 3'h4) |=> (o_int_connect == 4'h8 && o_ext_connect == 4'h0))
    else $error("Line amp routing wrong");
endmodule
`default_nettype wire

// ===== adcc_top.sv
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module adcc_top
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Interrupt enables and converter interrupt
  input wire logic i_conv_int_en,
  input wire logic i_global_int_en,
  output logic o_conv_int,
  // Analog core
  input wire logic i_cmp_high,
  output logic o_power_enable,
  output logic o_sample,
  output logic [RES_W-1:0] o_sar_code,
  output logic o_ref_from_supply,
  output logic [3:0] o_ext_channel_connect,
  output logic [3:0] o_int_source_connect,
  // Shared pins
  input wire logic [3:0] i_port_oe,
  input wire logic [3:0] i_port_pullhigh,
  output logic [3:0] o_pin_oe,
  output logic [3:0] o_pin_pullhigh,
  output logic o_vref_pin_ref
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Stored control fields and pin functions
  adcc_ctrl_t ctrl_q, ctrl_d;
  logic [3:0] pin_an_q, pin_an_d;
  logic [1:0] ref_fn_q, ref_fn_d;
  // Bus handshake and read data
  logic wait_q, wait_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic acc, wr_en, start_go, flag_clr;
  logic [7:0] wb;
  logic [15:0] res_pair;
  // Sequencer state, bit counter and successive-approximation code
  adcc_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [RES_W-1:0] sar_q, sar_d, data_q, data_d, sar_n;
  logic busy_q, busy_d, flag_q, flag_d, int_q, int_d, samp_d, samp_q;
  logic [3:0] bitpos;
  // Converter clock tick and tick count of the running conversion
  logic tick;
  logic [4:0] ticks_q, ticks_d;

  // ****************************************************************
  // Bus slave and registers
  // ****************************************************************
  always_comb begin
    acc = i_avs_read || i_avs_write;
    wr_en = i_avs_write && !wait_q && i_avs_byteenable[0];
    wb = i_avs_writedata[7:0];
    res_pair = adcc_format(data_q, ctrl_q.align);
    ctrl_d = ctrl_q;
    pin_an_d = pin_an_q;
    ref_fn_d = ref_fn_q;
    start_go = 1'b0;
    flag_clr = 1'b0;
    // Exactly one wait state: waitrequest drops for one cycle per access
    wait_d = !(acc && wait_q);
    // Read data holds until the next read
    rdata_d = rdata_q;
    // Writes land in the cycle in which waitrequest is low
    if (wr_en) begin
      case (i_avs_address)
        OFS_CTRL_FIRST: begin
          ctrl_d.start = wb[C0_START];
          ctrl_d.pwr = wb[C0_PWR];
          ctrl_d.align = wb[C0_ALIGN];
          ctrl_d.chan = wb[3:0];
          // Start fires on the write that clears a stored start bit
          start_go = ctrl_q.start && !wb[C0_START];
        end
        OFS_CTRL_SECOND: begin
          ctrl_d.src = wb[C1_SRC +: 3];
          ctrl_d.vref = wb[C1_VREF +: 2];
          ctrl_d.div = wb[C1_DIV +: 3];
        end
        OFS_PIN_FUNC: begin
          pin_an_d = wb[3:0];
          ref_fn_d = wb[PF_REF +: 2];
        end
        OFS_IRQ_STAT: flag_clr = wb[IRQ_FLAG];
        default: ;
      endcase
    end
    // Read data is prepared in the cycle before waitrequest drops
    if (i_avs_read && wait_q) begin
      case (i_avs_address)
        OFS_CTRL_FIRST: rdata_d = {24'h0, ctrl_q.start, busy_q, ctrl_q.pwr, ctrl_q.align,
                                   ctrl_q.chan};
        OFS_CTRL_SECOND: rdata_d = {24'h0, ctrl_q.src, ctrl_q.vref, ctrl_q.div};
        OFS_RES_HIGH: rdata_d = {24'h0, res_pair[15:8]};
        OFS_RES_LOW: rdata_d = {24'h0, res_pair[7:0]};
        OFS_PIN_FUNC: rdata_d = {26'h0, ref_fn_q, pin_an_q};
        OFS_IRQ_STAT: rdata_d = {31'h0, flag_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Register bus state and control fields
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= adcc_ctrl_t'({CTRL_RESET[7:0], 7'h00});
      pin_an_q <= 4'h0;
      ref_fn_q <= 2'h0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      pin_an_q <= pin_an_d;
      ref_fn_q <= ref_fn_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Converter clock
  // ****************************************************************
  adcc_clkdiv u_clkdiv (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_div(ctrl_q.div),
    .o_tick(tick)
  );

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sar_d = sar_q;
    data_d = data_q;
    busy_d = busy_q;
    // Cleared by software; a completion in the same cycle wins below
    flag_d = flag_q && !flag_clr;
    ticks_d = ticks_q;
    // Trial code: keep or drop the bit under test on the comparator,
    // then try the next lower bit as 1
    bitpos = 4'(RES_W - 1) - cnt_q;
    sar_n = sar_q;
    sar_n[bitpos] = i_cmp_high;
    if (bitpos != 4'h0) begin
      sar_n[bitpos - 4'h1] = 1'b1;
    end
    // Converter clocks spent so far, watched by the length check
    if (busy_q && tick) begin
      ticks_d = ticks_q + 5'h01;
    end
    case (state_q)
      ST_IDLE: begin
        // Start needs a stored power enable; a start while busy is ignored
        if (start_go && ctrl_q.pwr) begin
          state_d = ST_SAMPLE;
          busy_d = 1'b1;
          cnt_d = 4'h0;
          ticks_d = 5'h00;
          sar_d = SAR_INIT;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          if (cnt_q == SAMPLE_TICKS - 4'h1) begin
            state_d = ST_CONVERT;
            cnt_d = 4'h0;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          sar_d = sar_n;
          if (cnt_q == CONV_TICKS - 4'h1) begin
            state_d = ST_IDLE;
            // Result, busy and request flag all move on the last decision
            data_d = sar_n;
            busy_d = 1'b0;
            flag_d = 1'b1;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // Power-down aborts a conversion and keeps the old result
    if (!ctrl_q.pwr) begin
      state_d = ST_IDLE;
      busy_d = 1'b0;
      data_d = data_q;
    end
    // Output flags follow the next state so they line up with it
    samp_d = (state_d == ST_SAMPLE);
    int_d = flag_d && i_conv_int_en && i_global_int_en;
  end

  // Register sequencer state
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sar_q <= 12'h000;
      data_q <= 12'h000;
      busy_q <= 1'b0;
      flag_q <= 1'b0;
      int_q <= 1'b0;
      samp_q <= 1'b0;
      ticks_q <= 5'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sar_q <= sar_d;
      data_q <= data_d;
      busy_q <= busy_d;
      flag_q <= flag_d;
      int_q <= int_d;
      samp_q <= samp_d;
      ticks_q <= ticks_d;
    end
  end

  // ****************************************************************
  // Pin takeover and analog routing
  // ****************************************************************
  adcc_pinmux u_pinmux (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_analog_en(pin_an_q),
    .i_ref_fn(ref_fn_q),
    .i_chan(ctrl_q.chan),
    .i_src(ctrl_q.src),
    .i_vref(ctrl_q.vref),
    .i_port_oe(i_port_oe),
    .i_port_pullhigh(i_port_pullhigh),
    .o_pin_oe(o_pin_oe),
    .o_pin_pullhigh(o_pin_pullhigh),
    .o_vref_pin_ref(o_vref_pin_ref),
    .o_ref_supply(o_ref_from_supply),
    .o_ext_connect(o_ext_channel_connect),
    .o_int_connect(o_int_source_connect)
  );

  // Flop-driven outputs
  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_conv_int = int_q;
  assign o_power_enable = ctrl_q.pwr;
  assign o_sample = samp_q;
  assign o_sar_code = sar_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Start, busy and completion
  a_start_busy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (start_go && ctrl_q.pwr && !busy_q) |=> busy_q)
    else $error("Busy not set after start sequence");
  a_no_start_hi: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!busy_q && !(start_go && ctrl_q.pwr)) |=> !busy_q)
    else $error("Conversion began without start sequence");
  a_busy_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ($fell(busy_q) && ctrl_q.pwr) |-> (ticks_q == TOTAL_TICKS))
    else $error("Conversion did not take 16 converter clocks");
  a_done_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ($fell(busy_q) && ctrl_q.pwr) |-> flag_q)
    else $error("Request flag not set at completion");
  a_busy_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_q == ST_CONVERT && tick && cnt_q == 4'hb && ctrl_q.pwr) |=> !busy_q)
    else $error("Busy not cleared at completion");
  a_irq_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (flag_d && i_conv_int_en && i_global_int_en) |=> o_conv_int)
    else $error("Interrupt not raised");
  // Power-down and result holding
  a_off_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !ctrl_q.pwr |=> !busy_q)
    else $error("Busy while powered down");
  a_off_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !ctrl_q.pwr |=> $stable(data_q))
    else $error("Result changed while powered down");
  a_res_update: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (data_q != $past(data_q)) |-> ($fell(busy_q) && flag_q))
    else $error("Result changed outside completion");
  // Read-time formatting
  a_align_right: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_avs_read && wait_q && i_avs_address == OFS_RES_HIGH && ctrl_q.align)
      |=> (o_avs_readdata[7:4] == 4'h0))
    else $error("Unused high bits not zero");
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adcc_pkg::*;
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  logic mclk, rst_n, rd_en, wr_en, cie, gie, cmp;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] be, poe, pph, pin_oe, pin_ph, ext_c, int_c;
  logic wait_rq, conv_int, pwr_en, sample, ref_sup, vref_pin;
  logic [RES_W-1:0] sar, target;
  int n_mismatch = 0;
  int compares = 0;

  adcc_top i_dut (
    .i_mclk(mclk), .i_rst_n(rst_n),
    .i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en),
    .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
    .i_conv_int_en(cie), .i_global_int_en(gie), .o_conv_int(conv_int),
    .i_cmp_high(cmp), .o_power_enable(pwr_en), .o_sample(sample),
    .o_sar_code(sar), .o_ref_from_supply(ref_sup),
    .o_ext_channel_connect(ext_c), .o_int_source_connect(int_c),
    .i_port_oe(poe), .i_port_pullhigh(pph),
    .o_pin_oe(pin_oe), .o_pin_pullhigh(pin_ph), .o_vref_pin_ref(vref_pin)
  );

  // Comparator stand-in: analog input held at target
  assign cmp = (sar <= target);

  // Clock generator
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim;
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    addr <= a;
    wdata <= {24'h0, d};
    wr_en <= wr;
    rd_en <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (wait_rq !== 1'b0 && n < 20);
    q = rdata[7:0];
    if (n >= 20) begin
      chk(32'h0, 32'h1);
    end
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h0, q);
    chk({24'h0, q}, {24'h0, e});
  endtask

  // Full conversion: start sequence, timing, busy, flag and result
  task automatic conv(input logic [2:0] dv, input logic al, input logic [11:0] t);
    int n;
    int m;
    logic [15:0] f;
    target = t;
    f = al ? {4'h0, t} : {t, 4'h0};
    wr(OFS_CTRL_SECOND, {5'h0, dv});
    wr(OFS_CTRL_FIRST, {3'b101, al, 4'h0});
    repeat (8) @(posedge mclk);
    wr(OFS_CTRL_FIRST, {3'b001, al, 4'h0});
    #1;
    chk(sample, 1'b1);
    n = 0;
    m = 0;
    while (sample === 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n >= (3 << dv) + 1 && n <= (4 << dv), 1'b1);
    while (conv_int !== 1'b1 && m < 3000) begin
      @(posedge mclk);
      #1;
      m++;
    end
    chk(m, (12 << dv));
    rc(OFS_CTRL_FIRST, {3'b001, al, 4'h0});
    rc(OFS_IRQ_STAT, 8'h01);
    rc(OFS_RES_HIGH, f[15:8]);
    rc(OFS_RES_LOW, f[7:0]);
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    #(30000 * 20);
    n_mismatch++;
    end_sim();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [11:0] t;
    rst_n = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = '0;
    wdata = '0;
    be = 4'hf;
    cie = 1'b1;
    gie = 1'b1;
    poe = 4'hf;
    pph = 4'hc;
    target = 12'h0;
    t = 12'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(wait_rq, 1'b1);
    rc(OFS_CTRL_FIRST, 8'h00);
    rc(OFS_CTRL_SECOND, 8'h00);
    // Refused accesses: unmapped, no byte enable, read-only busy
    rc(5'h18, 8'h00);
    wr(OFS_CTRL_SECOND, 8'h05);
    be <= 4'h0;
    wr(OFS_CTRL_SECOND, 8'hff);
    be <= 4'hf;
    rc(OFS_CTRL_SECOND, 8'h05);
    wr(OFS_CTRL_FIRST, 8'h40);
    rc(OFS_CTRL_FIRST, 8'h00);
    // Input source, channel and reference routing
    wr(OFS_CTRL_FIRST, 8'h02);
    for (int s = 0; s < 8; s++) begin
      wr(OFS_CTRL_FIRST, 8'h0c);
      wr(OFS_CTRL_SECOND, {3'(s), 2'(s), 3'h0});
      if (s == 0 || s > 4) begin
        wr(OFS_CTRL_FIRST, 8'h02);
      end
      repeat (2) @(posedge mclk);
      chk(ext_c, (s == 0 || s > 4) ? 4'h4 : 4'h0);
      chk(int_c, (s >= 1 && s <= 4) ? 4'(1 << (s - 1)) : 4'h0);
      chk(ref_sup, 2'(s) == 2'h1);
    end
    wr(OFS_CTRL_FIRST, 8'h03);
    wr(OFS_CTRL_SECOND, 8'h00);
    repeat (2) @(posedge mclk);
    chk(ext_c, 4'h8);
    wr(OFS_CTRL_FIRST, 8'h04);
    repeat (2) @(posedge mclk);
    chk(ext_c, 4'h0);
    // Shared pin takeover
    wr(OFS_PIN_FUNC, 8'h15);
    repeat (2) @(posedge mclk);
    chk(pin_oe, 4'ha);
    chk(pin_ph, 4'h8);
    chk(vref_pin, 1'b1);
    wr(OFS_PIN_FUNC, 8'h20);
    repeat (2) @(posedge mclk);
    chk({vref_pin, pin_oe, pin_ph}, 9'h0fc);
    wr(OFS_PIN_FUNC, 8'h13);
    // Every divider code, both alignments
    for (int d = 0; d < 8; d++) begin
      t = 12'h5a3 + 12'(d * 12'h211);
      conv(3'(d), d[0], t);
      wr(OFS_IRQ_STAT, 8'h01);
      rc(OFS_IRQ_STAT, 8'h00);
    end
    // Interrupt gating by both enables, then clear
    conv(3'h6, 1'b0, 12'hfff);
    gie <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(conv_int, 1'b0);
    gie <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(conv_int, 1'b1);
    cie <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(conv_int, 1'b0);
    cie <= 1'b1;
    wr(OFS_IRQ_STAT, 8'h01);
    repeat (2) @(posedge mclk);
    chk(conv_int, 1'b0);
    // Power-down in mid-conversion aborts and keeps the result
    wr(OFS_CTRL_SECOND, 8'h07);
    wr(OFS_CTRL_FIRST, 8'ha0);
    wr(OFS_CTRL_FIRST, 8'h20);
    rc(OFS_CTRL_FIRST, 8'h60);
    chk(pwr_en, 1'b1);
    wr(OFS_CTRL_FIRST, 8'h00);
    repeat (2) @(posedge mclk);
    chk(pwr_en, 1'b0);
    rc(OFS_CTRL_FIRST, 8'h00);
    repeat (2100) @(posedge mclk);
    rc(OFS_IRQ_STAT, 8'h00);
    rc(OFS_RES_HIGH, 8'hff);
    rc(OFS_RES_LOW, 8'hf0);
    // Start with power off is ignored
    wr(OFS_CTRL_FIRST, 8'h80);
    wr(OFS_CTRL_FIRST, 8'h00);
    rc(OFS_CTRL_FIRST, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
